// [hdl/usps_cfg.svh]
// Register offsets, field positions, reset values and timing figures of the frame scheduler
`ifndef USPS_CFG_SVH
`define USPS_CFG_SVH
`define USPS_SYSTEM_CONFIG_REGISTER_OFS   12'h000
`define USPS_DVSTCTR_OFS  12'h004
`define USPS_FRAME_NUMBER_REGISTER_OFS   12'h008
`define USPS_MSTOP_OFS    12'h00c
`define USPS_PIPE_PAGE    6'h01
`define USPS_NPIPE        10
`define USPS_SYS_MEN_BIT  0
`define USPS_SYS_MCE_BIT  1
`define USPS_SYS_HOST_BIT 2
`define USPS_DV_HOST_BUS_ACTIVITY_BIT_BIT  0
`define USPS_DV_SETUP_REQUEST_BIT_BIT 1
`define USPS_DV_SUSP_BIT  2
`define USPS_DV_RUN_BIT   3
`define USPS_PC_RESP_LSB  0
`define USPS_PC_DIR_BIT   2
`define USPS_PC_TYPE_LSB  3
`define USPS_PC_INTERVAL_SETTING_FIELD_LSB  5
`define USPS_SYS_RST      3'h0
`define USPS_PCFG_RST     8'h00
`define USPS_MSTOP_RST    1'b1
`define USPS_CLK_NS       10
`define USPS_FRAME_NS     1000000
`define USPS_GUARD_NS     20000
`endif

// [hdl/usps_pkg.sv]
// Types shared by the frame interpolation and pipe scheduling logic
package usps_pkg;
  typedef enum logic [1:0] {resp_nak = 2'h0, resp_buf = 2'h1} usps_resp_t;
  typedef enum logic [1:0] {ptype_bulk = 2'h0, ptype_intr = 2'h1, ptype_iso = 2'h2} usps_ptype_t;
  typedef enum logic [1:0] {kind_setup = 2'h0, kind_in = 2'h1, kind_out = 2'h2} usps_kind_t;
  typedef enum logic [2:0] {
    st_idle  = 3'h0,
    st_per   = 3'h1,
    st_setup = 3'h2,
    st_np    = 3'h3,
    st_wait  = 3'h4
  } usps_state_t;
  typedef struct packed {
    logic       valid;
    logic [3:0] pipe;
    usps_kind_t kind;
    logic       zlp;
    logic       discard;
  } usps_txn_t;
  typedef struct packed {
    logic        valid;
    logic [10:0] frnum;
  } usps_sof_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } usps_apb_req_t;
endpackage : usps_pkg

// [hdl/usps_sched.sv]
// Frame interpolation (function mode) and pipe transaction scheduler (host mode)
// Contract
// - Function mode: synthesize a frame event when an expected frame packet is lost.
// - Interpolation starts only after both enable bits are 1 and a frame packet arrives.
// - Power-on reset, bus reset and suspend return interpolation to inactive.
// - After the first frame packet, interpolated frames are timed as one millisecond.
// - After two or more packets, the measured interval becomes the period.
// - No interpolated frames while suspended or while bus reset is received.
// - Interpolated frames drive the frame tick and interval counting like real ones.
// - The 11-bit frame number stays unchanged on interpolated frames.
// - Host mode: transactions only while bus activity is 1; setup on request bit.
// - Bulk and control stages go on buffer response with space or data, no interval.
// - Interrupt and isochronous pipes run only in frames chosen by the interval counter.
// - Isochronous IN issues even with no space; received data is then discarded.
// - Isochronous OUT issues even with no data; a zero-length packet is then sent.
// - After each frame start, scan periodic pipes in order 1,2,6,7,8,9.
// - Then check the default control pipe for a setup transaction.
// - Then scan default control pipe and pipes 1 to 5 for bulk and control stages.
// - Advance after every transaction; repeat the scan while frame time remains.
// - Activity bit 1 starts frames; clearing it stops after the next frame start.
// - Module is stopped after reset; registers open only after release.
//
// The address map and the APB slave port were left to the implementer.
`include "usps_cfg.svh"

module usps_sched #(
  parameter int FRAME_CYC = `USPS_FRAME_NS / `USPS_CLK_NS
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire usps_pkg::usps_apb_req_t apb_req,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  input  wire usps_pkg::usps_sof_t     sof_rx,
  input  wire logic                    bus_reset,
  input  wire logic                    suspend,
  input  wire logic [9:0]              rx_space,
  input  wire logic [9:0]              tx_pend,
  input  wire logic                    txn_done,
  output logic                         frame_tick,
  output logic                         frame_interp,
  output logic                         sof_tx,
  output logic [10:0]                  frame_num,
  output usps_pkg::usps_txn_t          txn
);

  localparam int GUARD_CYC = `USPS_GUARD_NS / `USPS_CLK_NS;

  logic [2:0]                  sys_ff;
  logic                        host_bus_activity_bit_ff;
  logic                        setup_request_bit_ff;
  logic                        mstop_ff;
  logic [7:0]                  pcfg_ff [`USPS_NPIPE];
  logic                        pready_ff;
  logic [31:0]                 prdata_ff;
  logic                        pslverr_ff;
  logic [31:0]                 rdata;
  logic                        mapped;
  logic                        acc_ok;
  logic                        wr_commit;
  logic                        rd_access;
  logic [11:0]                 addr;
  logic [3:0]                  pidx;
  logic                        is_pipe;
  logic                        arm_ff;
  logic                        two_ff;
  logic                        miss_ff;
  logic                        run_ff;
  logic [19:0]                 cnt_ff;
  logic [19:0]                 period_ff;
  logic                        tick_ff;
  logic                        interp_ff;
  logic                        sof_tx_ff;
  logic [10:0]                 frnum_ff;
  logic                        host;
  logic                        dev_en;
  logic                        kill;
  logic                        go;
  logic                        time_left;
  logic [9:0]                  due_ff;
  logic [9:0]                  per_ok;
  logic [9:0]                  np_ok;
  usps_pkg::usps_state_t       st_ff;
  usps_pkg::usps_state_t       ret_ff;
  logic [2:0]                  idx_ff;
  usps_pkg::usps_txn_t         txn_ff;
  logic [3:0]                  cur_p;
  logic                        cur_dir;
  logic                        cur_iso;
  logic                        setup_go;

  function automatic logic [3:0] per_pipe(input logic [2:0] i);
    case (i)
      3'h0:    per_pipe = 4'h1;
      3'h1:    per_pipe = 4'h2;
      3'h2:    per_pipe = 4'h6;
      3'h3:    per_pipe = 4'h7;
      3'h4:    per_pipe = 4'h8;
      default: per_pipe = 4'h9;
    endcase
  endfunction : per_pipe

  assign pready       = pready_ff;
  assign prdata       = prdata_ff;
  assign pslverr      = pslverr_ff;
  assign frame_tick   = tick_ff;
  assign frame_interp = interp_ff;
  assign sof_tx       = sof_tx_ff;
  assign frame_num    = frnum_ff;
  assign txn          = txn_ff;

  // APB decode
  assign addr      = apb_req.paddr;
  assign is_pipe   = (addr[11:6] == `USPS_PIPE_PAGE) && (addr[5:2] < 4'(`USPS_NPIPE));
  assign pidx      = addr[5:2];
  assign acc_ok    = !mstop_ff || (addr == `USPS_MSTOP_OFS);
  assign rd_access = apb_req.psel && apb_req.penable && !pready_ff;
  assign wr_commit = apb_req.psel && apb_req.penable && apb_req.pwrite && pready_ff
                     && acc_ok && mapped;

  always_comb begin
    rdata  = 32'h0000_0000;
    mapped = 1'b1;
    if (is_pipe) begin
      rdata[7:0] = pcfg_ff[pidx];
    end else begin
      case (addr)
        `USPS_SYSTEM_CONFIG_REGISTER_OFS:  rdata[2:0] = sys_ff;
        `USPS_DVSTCTR_OFS: begin
          rdata[`USPS_DV_HOST_BUS_ACTIVITY_BIT_BIT]  = host_bus_activity_bit_ff;
          rdata[`USPS_DV_SETUP_REQUEST_BIT_BIT] = setup_request_bit_ff;
          rdata[`USPS_DV_SUSP_BIT]  = host ? !run_ff : suspend;
          rdata[`USPS_DV_RUN_BIT]   = run_ff;
        end
        `USPS_FRAME_NUMBER_REGISTER_OFS:  rdata[10:0] = frnum_ff;
        `USPS_MSTOP_OFS:   rdata[0] = mstop_ff;
        default:           mapped = 1'b0;
      endcase
    end
  end

  // Answer one cycle into the access phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= rd_access;
      if (rd_access) begin
        prdata_ff  <= (acc_ok && mapped) ? rdata : 32'h0000_0000;
        pslverr_ff <= !(acc_ok && mapped);
      end else begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // Control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_ff   <= `USPS_SYS_RST;
      host_bus_activity_bit_ff  <= 1'b0;
      setup_request_bit_ff <= 1'b0;
      mstop_ff <= `USPS_MSTOP_RST;
    end else begin
      if (wr_commit && addr == `USPS_SYSTEM_CONFIG_REGISTER_OFS) begin
        sys_ff <= apb_req.pwdata[2:0];
      end
      if (wr_commit && addr == `USPS_MSTOP_OFS) begin
        mstop_ff <= apb_req.pwdata[0];
      end
      if (wr_commit && addr == `USPS_DVSTCTR_OFS) begin
        host_bus_activity_bit_ff  <= apb_req.pwdata[`USPS_DV_HOST_BUS_ACTIVITY_BIT_BIT];
        setup_request_bit_ff <= apb_req.pwdata[`USPS_DV_SETUP_REQUEST_BIT_BIT];
      end else if (setup_go) begin
        setup_request_bit_ff <= 1'b0;
      end
    end
  end

  assign host   = sys_ff[`USPS_SYS_HOST_BIT];
  assign dev_en = sys_ff[`USPS_SYS_MEN_BIT] && sys_ff[`USPS_SYS_MCE_BIT] && !mstop_ff;
  assign kill   = !dev_en || bus_reset || suspend || host;

  // Frame timing for both modes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_ff    <= 1'b0;
      two_ff    <= 1'b0;
      miss_ff   <= 1'b0;
      run_ff    <= 1'b0;
      cnt_ff    <= 20'h00000;
      period_ff <= 20'(FRAME_CYC);
      tick_ff   <= 1'b0;
      interp_ff <= 1'b0;
      sof_tx_ff <= 1'b0;
      frnum_ff  <= 11'h000;
    end else if (host) begin
      arm_ff    <= 1'b0;
      two_ff    <= 1'b0;
      miss_ff   <= 1'b0;
      period_ff <= 20'(FRAME_CYC);
      interp_ff <= 1'b0;
      tick_ff   <= 1'b0;
      sof_tx_ff <= 1'b0;
      if (!dev_en) begin
        run_ff <= 1'b0;
        cnt_ff <= 20'h00000;
      end else if (!run_ff) begin
        cnt_ff <= 20'h00000;
        if (host_bus_activity_bit_ff) begin
          run_ff <= 1'b1;
        end
      end else if (cnt_ff == 20'(FRAME_CYC - 1)) begin
        cnt_ff    <= 20'h00000;
        sof_tx_ff <= 1'b1;
        tick_ff   <= 1'b1;
        frnum_ff  <= frnum_ff + 11'h001;
        if (!host_bus_activity_bit_ff) begin
          run_ff <= 1'b0;
        end
      end else begin
        cnt_ff <= cnt_ff + 20'h00001;
      end
    end else begin
      run_ff    <= 1'b0;
      sof_tx_ff <= 1'b0;
      if (kill) begin
        arm_ff    <= 1'b0;
        two_ff    <= 1'b0;
        miss_ff   <= 1'b0;
        cnt_ff    <= 20'h00000;
        period_ff <= 20'(FRAME_CYC);
        tick_ff   <= 1'b0;
        interp_ff <= 1'b0;
      end else if (sof_rx.valid) begin
        arm_ff    <= 1'b1;
        cnt_ff    <= 20'h00000;
        tick_ff   <= 1'b1;
        interp_ff <= 1'b0;
        miss_ff   <= 1'b0;
        frnum_ff  <= sof_rx.frnum;
        if (arm_ff && !miss_ff) begin
          period_ff <= cnt_ff + 20'h00001;
          two_ff    <= 1'b1;
        end
      end else if (arm_ff && cnt_ff == period_ff - 20'h00001) begin
        cnt_ff    <= 20'h00000;
        tick_ff   <= 1'b1;
        interp_ff <= 1'b1;
        miss_ff   <= 1'b1;
      end else begin
        tick_ff   <= 1'b0;
        interp_ff <= 1'b0;
        if (arm_ff) begin
          cnt_ff <= cnt_ff + 20'h00001;
        end
      end
    end
  end

  // Per-pipe configuration, interval counting and eligibility
  genvar gi;
  generate
    for (gi = 0; gi < `USPS_NPIPE; gi++) begin : g_pipe
      logic [7:0] ivl_ff;
      logic [2:0] interval_setting_field;
      logic       is_buf;
      logic       dir_out;
      logic       data_ok;
      logic [1:0] ptype;
      assign interval_setting_field    = pcfg_ff[gi][`USPS_PC_INTERVAL_SETTING_FIELD_LSB +: 3];
      assign is_buf  = pcfg_ff[gi][`USPS_PC_RESP_LSB +: 2] == usps_pkg::resp_buf;
      assign dir_out = pcfg_ff[gi][`USPS_PC_DIR_BIT];
      assign ptype   = pcfg_ff[gi][`USPS_PC_TYPE_LSB +: 2];
      assign data_ok = dir_out ? tx_pend[gi] : rx_space[gi];
      assign per_ok[gi] = is_buf && due_ff[gi] && (ptype == usps_pkg::ptype_iso ||
                          (ptype == usps_pkg::ptype_intr && data_ok));
      assign np_ok[gi]  = is_buf && ptype == usps_pkg::ptype_bulk && data_ok;

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pcfg_ff[gi] <= `USPS_PCFG_RST;
        end else if (wr_commit && is_pipe && pidx == 4'(gi)) begin
          pcfg_ff[gi] <= apb_req.pwdata[7:0];
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ivl_ff     <= 8'h00;
          due_ff[gi] <= 1'b0;
        end else if (!is_buf) begin
          ivl_ff     <= 8'h00;
          due_ff[gi] <= 1'b0;
        end else if (tick_ff) begin
          due_ff[gi] <= ivl_ff == 8'h00;
          ivl_ff     <= (ivl_ff == 8'h00) ? (8'h01 << interval_setting_field) - 8'h01 : ivl_ff - 8'h01;
        end else if (txn_ff.valid && txn_ff.pipe == 4'(gi)) begin
          due_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Scheduler
  assign go        = host && host_bus_activity_bit_ff && run_ff;
  assign time_left = (FRAME_CYC > GUARD_CYC) && (cnt_ff < 20'(FRAME_CYC - GUARD_CYC));
  assign cur_p     = (st_ff == usps_pkg::st_per) ? per_pipe(idx_ff) : {1'b0, idx_ff};
  assign cur_dir   = pcfg_ff[cur_p][`USPS_PC_DIR_BIT];
  assign cur_iso   = pcfg_ff[cur_p][`USPS_PC_TYPE_LSB +: 2] == usps_pkg::ptype_iso;
  assign setup_go  = go && !sof_tx_ff && st_ff == usps_pkg::st_setup && setup_request_bit_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff  <= usps_pkg::st_idle;
      ret_ff <= usps_pkg::st_idle;
      idx_ff <= 3'h0;
      txn_ff <= '0;
    end else begin
      txn_ff <= '0;
      if (!go) begin
        st_ff <= usps_pkg::st_idle;
      end else if (sof_tx_ff && st_ff != usps_pkg::st_wait) begin
        st_ff  <= usps_pkg::st_per;
        idx_ff <= 3'h0;
      end else begin
        case (st_ff)
          usps_pkg::st_per: begin
            if (idx_ff == 3'h6) begin
              st_ff <= usps_pkg::st_setup;
            end else begin
              idx_ff <= idx_ff + 3'h1;
              if (per_ok[cur_p]) begin
                txn_ff.valid   <= 1'b1;
                txn_ff.pipe    <= cur_p;
                txn_ff.kind    <= cur_dir ? usps_pkg::kind_out : usps_pkg::kind_in;
                txn_ff.zlp     <= cur_iso && cur_dir && !tx_pend[cur_p];
                txn_ff.discard <= cur_iso && !cur_dir && !rx_space[cur_p];
                ret_ff         <= usps_pkg::st_per;
                st_ff          <= usps_pkg::st_wait;
              end
            end
          end
          usps_pkg::st_setup: begin
            idx_ff <= 3'h0;
            if (setup_request_bit_ff) begin
              txn_ff.valid <= 1'b1;
              txn_ff.pipe  <= 4'h0;
              txn_ff.kind  <= usps_pkg::kind_setup;
              ret_ff       <= usps_pkg::st_np;
              st_ff        <= usps_pkg::st_wait;
            end else begin
              st_ff <= usps_pkg::st_np;
            end
          end
          usps_pkg::st_np: begin
            if (idx_ff == 3'h6) begin
              if (time_left) begin
                idx_ff <= 3'h0;
              end else begin
                st_ff <= usps_pkg::st_idle;
              end
            end else begin
              idx_ff <= idx_ff + 3'h1;
              if (np_ok[cur_p]) begin
                txn_ff.valid <= 1'b1;
                txn_ff.pipe  <= cur_p;
                txn_ff.kind  <= cur_dir ? usps_pkg::kind_out : usps_pkg::kind_in;
                ret_ff       <= usps_pkg::st_np;
                st_ff        <= usps_pkg::st_wait;
              end
            end
          end
          usps_pkg::st_wait: begin
            if (txn_done) begin
              st_ff <= ret_ff;
            end
          end
          usps_pkg::st_idle: begin
            idx_ff <= 3'h0;
          end
          default: st_ff <= usps_pkg::st_idle;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_interp_tick;
    tick_ff && interp_ff;
  endsequence

  property p_interp_period;
    s_interp_tick |-> $past(cnt_ff) == $past(period_ff) - 20'h00001;
  endproperty
  a_interp_period: assert property (p_interp_period) else $error("interp tick off period");

  property p_arm_start;
    !arm_ff && !sof_rx.valid |=> !arm_ff;
  endproperty
  a_arm_start: assert property (p_arm_start) else $error("armed without frame packet");

  property p_kill;
    bus_reset || suspend |=> !arm_ff && !tick_ff;
  endproperty
  a_kill: assert property (p_kill) else $error("active during reset or suspend");

  property p_first_period;
    arm_ff && !two_ff && !host |-> period_ff == 20'(FRAME_CYC);
  endproperty
  a_first_period: assert property (p_first_period) else $error("first period not nominal");

  property p_frnum_hold;
    s_interp_tick |-> frnum_ff == $past(frnum_ff);
  endproperty
  a_frnum_hold: assert property (p_frnum_hold) else $error("frame number moved");

  property p_txn_host_bus_activity_bit;
    txn_ff.valid |-> $past(host_bus_activity_bit_ff) && $past(host);
  endproperty
  a_txn_host_bus_activity_bit: assert property (p_txn_host_bus_activity_bit) else $error("transaction without activity");

  property p_setup_dcp;
    txn_ff.valid && txn_ff.kind == usps_pkg::kind_setup |-> txn_ff.pipe == 4'h0 && !setup_request_bit_ff;
  endproperty
  a_setup_dcp: assert property (p_setup_dcp) else $error("setup not on control pipe");

  property p_zlp_dir;
    txn_ff.valid && (txn_ff.zlp || txn_ff.discard) |->
      (txn_ff.zlp ? txn_ff.kind == usps_pkg::kind_out : txn_ff.kind == usps_pkg::kind_in);
  endproperty
  a_zlp_dir: assert property (p_zlp_dir) else $error("zero length flag on wrong dir");

  property p_stop;
    sof_tx_ff && !$past(host_bus_activity_bit_ff) |-> !run_ff;
  endproperty
  a_stop: assert property (p_stop) else $error("frames continue after stop");

  property p_sof_count;
    sof_tx_ff |-> frnum_ff == $past(frnum_ff) + 11'h001 && tick_ff;
  endproperty
  a_sof_count: assert property (p_sof_count) else $error("frame number not incremented");

  property p_mstop;
    pready_ff && mstop_ff && $past(addr) != `USPS_MSTOP_OFS |-> pslverr_ff;
  endproperty
  a_mstop: assert property (p_mstop) else $error("access while module stopped");

endmodule : usps_sched

// [verif/usps_far_model.sv]
// Far-side bus model: frame packets on request, transaction completion after a delay
module usps_far_model (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                sof_req,
  input  wire logic [10:0]         sof_num,
  input  wire logic [2:0]          resp_dly,
  input  wire usps_pkg::usps_txn_t txn,
  output usps_pkg::usps_sof_t      sof_rx,
  output logic                     txn_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_ff;
  logic       busy_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sof_rx <= '0;
    end else begin
      sof_rx.valid <= sof_req;
      // Number field toggles outside packets
      sof_rx.frnum <= sof_req ? sof_num : ~sof_rx.frnum;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff  <= 1'b0;
      wait_ff  <= 3'h0;
      txn_done <= 1'b0;
    end else begin
      txn_done <= 1'b0;
      if (txn.valid) begin
        busy_ff <= 1'b1;
        wait_ff <= resp_dly;
      end else if (busy_ff && wait_ff == 3'h0) begin
        busy_ff  <= 1'b0;
        txn_done <= 1'b1;
      end else if (busy_ff) begin
        wait_ff <= wait_ff - 3'h1;
      end
    end
  end
endmodule : usps_far_model

// [verif/usps_sof_interp_pipe_scheduler_tb_top.sv]
// Self-checking bench for frame interpolation and pipe scheduling
`include "usps_cfg.svh"
module usps_sof_interp_pipe_scheduler_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FC = 200;
  typedef struct {logic ip; logic [10:0] num; int gap;} usps_tick_t;
  typedef struct {logic [31:0] d; logic e; logic rd;} usps_rd_t;
  logic clk = 1'b0, rst_n = 1'b0, bus_reset = 1'b0, suspend = 1'b0, sof_req = 1'b0;
  logic host = 1'b0;
  logic [10:0] sof_num = '0, num, last_num;
  logic [9:0] rx_space = '0, tx_pend = '0;
  logic [2:0] resp_dly = 3'h1;
  logic [7:0] pc [10] = '{8'h05, 8'h11, 8'h0d, 8'h01, 8'h01, 8'h00, 8'h15, 8'h09, 8'h00, 8'h00};
  usps_pkg::usps_apb_req_t apb = '0;
  logic pready, pslverr, frame_tick, frame_interp, sof_tx, txn_done;
  logic [31:0] prdata;
  logic [10:0] frame_num;
  usps_pkg::usps_sof_t sof_rx;
  usps_pkg::usps_txn_t txn;
  usps_tick_t tick_q[$];
  usps_rd_t rd_q[$];
  usps_pkg::usps_txn_t txn_q[$];
  int miscompares = 0, n_tests = 0, cyc = 0, last_t = 0, last_s = 0, n_sof = 0, n0;
  always #5 clk = ~clk;
  usps_sched #(.FRAME_CYC(FC)) uut (.clk(clk), .rst_n(rst_n), .apb_req(apb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .sof_rx(sof_rx), .bus_reset(bus_reset),
    .suspend(suspend), .rx_space(rx_space), .tx_pend(tx_pend), .txn_done(txn_done),
    .frame_tick(frame_tick), .frame_interp(frame_interp), .sof_tx(sof_tx),
    .frame_num(frame_num), .txn(txn));
  usps_far_model far (.clk(clk), .rst_n(rst_n), .sof_req(sof_req), .sof_num(sof_num),
    .resp_dly(resp_dly), .txn(txn), .sof_rx(sof_rx), .txn_done(txn_done));
  task automatic bad(input string what);
    miscompares++;
    $display("ERROR %s", what);
  endtask : bad
  task automatic chk_frame(input usps_tick_t n, input int gap);
    n_tests++;
    if (frame_interp !== n.ip || frame_num !== n.num ||
        (n.gap != 0 && (gap < n.gap - 2 || gap > n.gap + 2)))
      bad($sformatf("frame expected ip=%0b num=%h gap=%0d seen ip=%0b num=%h gap=%0d",
                    n.ip, n.num, n.gap, frame_interp, frame_num, gap));
  endtask : chk_frame
  task automatic chk_txn(input usps_pkg::usps_txn_t e);
    n_tests++;
    if (txn !== e)
      bad($sformatf("txn expected %h seen %h", e, txn));
  endtask : chk_txn
  task automatic chk_apb(input usps_rd_t e);
    n_tests++;
    if (pslverr !== e.e || (e.rd && prdata !== e.d))
      bad($sformatf("apb expected %h/%b seen %h/%b", e.d, e.e, prdata, pslverr));
  endtask : chk_apb
  task automatic chk_cnt(input string what, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (e !== s)
      bad($sformatf("%s expected %0d seen %0d", what, e, s));
  endtask : chk_cnt
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  function automatic usps_pkg::usps_txn_t mk(input logic [3:0] p, input usps_pkg::usps_kind_t k,
                                             input logic z, input logic d);
    return '{1'b1, p, k, z, d};
  endfunction : mk
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad($sformatf("timeout expected finish before %0d cycles seen %0d", 20000, cyc));
      stop_test();
    end
    if (frame_tick === 1'b1 && !host) begin
      if (tick_q.size() == 0) bad("frame_tick expected none seen 1");
      else chk_frame(tick_q.pop_front(), cyc - last_t);
      last_t = cyc;
    end
    if (sof_tx === 1'b1) begin
      if (n_sof > 0) chk_cnt("sof gap", FC, cyc - last_s);
      if (n_sof > 0) chk_cnt("sof number", 11'(last_num + 11'h1), frame_num);
      n_sof++;
      last_num = frame_num;
      last_s = cyc;
    end
    if (txn.valid === 1'b1) begin
      resp_dly <= 3'($urandom_range(1, 6));
      if (txn_q.size() == 0) bad("txn expected none seen valid");
      else chk_txn(txn_q.pop_front());
    end
    if (apb.psel && apb.penable && pready === 1'b1 && rd_q.size() > 0)
      chk_apb(rd_q.pop_front());
  end
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                          input logic [31:0] ed, input logic ee);
    rd_q.push_back('{ed, ee, !wr});
    apb <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
    @(posedge clk);
  endtask : apb_xfer
  task automatic send_sof(input logic [10:0] n);
    sof_req <= 1'b1;
    sof_num <= n;
    @(posedge clk);
    sof_req <= 1'b0;
  endtask : send_sof
  task automatic drain;
    int n;
    n = 0;
    while ((tick_q.size() > 0 || txn_q.size() > 0) && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask : drain
  initial begin
    void'($urandom(32'h6f5c0332));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb_xfer(1'b0, `USPS_MSTOP_OFS, 0, 32'h1, 1'b0);
    apb_xfer(1'b1, `USPS_SYSTEM_CONFIG_REGISTER_OFS, 32'h3, 0, 1'b1);
    apb_xfer(1'b1, `USPS_MSTOP_OFS, 0, 0, 1'b0);
    apb_xfer(1'b0, `USPS_SYSTEM_CONFIG_REGISTER_OFS, 0, 32'h0, 1'b0);
    apb_xfer(1'b0, 12'h100, 0, 32'h0, 1'b1);
    send_sof(11'h123);
    cycles(100);
    apb_xfer(1'b1, `USPS_SYSTEM_CONFIG_REGISTER_OFS, 32'h3, 0, 1'b0);
    cycles(300);
    tick_q.push_back('{1'b0, 11'h005, 0});
    send_sof(11'h005);
    cycles(149);
    tick_q.push_back('{1'b0, 11'h006, 150});
    tick_q.push_back('{1'b1, 11'h006, 150});
    tick_q.push_back('{1'b1, 11'h006, 150});
    send_sof(11'h006);
    drain();
    for (int k = 0; k < 2; k++) begin
      num = 11'($urandom);
      tick_q.push_back('{1'b0, num, 0});
      send_sof(num);
      cycles(50);
      if (k == 1) bus_reset <= 1'b1;
      else suspend <= 1'b1;
      send_sof(11'(num + 11'h1));
      cycles(400);
      bus_reset <= 1'b0;
      suspend <= 1'b0;
      cycles(300);
      tick_q.push_back('{1'b0, 11'(num + 11'h2), 0});
      tick_q.push_back('{1'b1, 11'(num + 11'h2), FC});
      send_sof(11'(num + 11'h2));
      drain();
    end
    apb_xfer(1'b1, `USPS_SYSTEM_CONFIG_REGISTER_OFS, 32'h7, 0, 1'b0);
    host <= 1'b1;
    for (int i = 0; i < 10; i++) apb_xfer(1'b1, 12'(12'h040 + 4 * i), {24'h0, pc[i]}, 0, 1'b0);
    tx_pend <= 10'h005;
    rx_space <= 10'h008;
    cycles(300);
    txn_q.push_back(mk(4'h1, usps_pkg::kind_in, 1'b0, 1'b1));
    txn_q.push_back(mk(4'h2, usps_pkg::kind_out, 1'b0, 1'b0));
    txn_q.push_back(mk(4'h6, usps_pkg::kind_out, 1'b1, 1'b0));
    txn_q.push_back(mk(4'h0, usps_pkg::kind_setup, 1'b0, 1'b0));
    txn_q.push_back(mk(4'h0, usps_pkg::kind_out, 1'b0, 1'b0));
    txn_q.push_back(mk(4'h3, usps_pkg::kind_in, 1'b0, 1'b0));
    apb_xfer(1'b1, `USPS_DVSTCTR_OFS, 32'h3, 0, 1'b0);
    drain();
    apb_xfer(1'b1, 12'h044, 32'h0, 0, 1'b0);
    apb_xfer(1'b1, 12'h058, 32'h0, 0, 1'b0);
    tx_pend <= 10'h000;
    rx_space <= 10'h000;
    cycles(FC);
    n0 = n_sof;
    apb_xfer(1'b1, `USPS_DVSTCTR_OFS, 32'h0, 0, 1'b0);
    cycles(3 * FC);
    chk_cnt("sof after stop", n0 + 1, n_sof);
    apb_xfer(1'b0, `USPS_DVSTCTR_OFS, 0, 32'h4, 1'b0);
    chk_cnt("pending notes", 0, tick_q.size() + txn_q.size() + rd_q.size());
    stop_test();
  end
endmodule : usps_sof_interp_pipe_scheduler_tb_top
